/* rtl/picc_pkg.sv */
// constants and types of the priority interrupt controller
package picc_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int         NLVL          = 8;
   localparam int         LW            = 3;
   localparam logic [2:0] SPURIOUS_LVL  = 3'h7;
   localparam logic [2:0] BOTTOM_RST    = 3'h7;
   localparam logic [7:0] MASK_RST      = 8'h00;
   localparam logic [7:0] ZERO8         = 8'h00;
   localparam logic [7:0] ONE8          = 8'h01;
   // ---------------------------------------------------------------
   // port select: command/status port and data/mask port
   // ---------------------------------------------------------------
   localparam logic       PORT_CMD      = 1'b0;
   localparam logic       PORT_DATA     = 1'b1;
   // ---------------------------------------------------------------
   // command word fields
   // ---------------------------------------------------------------
   localparam int         W1_ID0        = 0;
   localparam int         W1_SINGLE     = 1;
   localparam int         W1_LEVEL      = 3;
   localparam int         W1_ID4        = 4;
   localparam int         OCW_SEL3      = 3;
   localparam int         VEC_HI        = 7;
   localparam int         VEC_LO        = 3;
   localparam int         W4_UPM        = 0;
   localparam int         W4_AUTO       = 1;
   localparam int         W4_MS         = 2;
   localparam int         W4_BUF        = 3;
   localparam int         W4_SFN        = 4;
   localparam int         OC2_HI        = 7;
   localparam int         OC2_LO        = 5;
   localparam logic [2:0] OC2_SETPRI    = 3'h6;
   localparam logic [2:0] OC2_ROT_ON    = 3'h4;
   localparam logic [2:0] OC2_ROT_OFF   = 3'h0;
   localparam int         OC2_EOI_B     = 0;
   localparam int         OC2_SPEC_B    = 1;
   localparam int         OC2_ROT_B     = 2;
   localparam int         OC3_SPECIAL_MASK_WRITE_ENABLE      = 6;
   localparam int         OC3_SMM       = 5;
   localparam int         OC3_POLL      = 2;
   localparam int         OC3_RR        = 1;
   localparam int         OC3_RIS       = 0;
   localparam logic [3:0] POLL_PAD      = 4'h0;
   // ---------------------------------------------------------------
   // state types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      INIT_WAIT, INIT_VEC, INIT_CASC, INIT_FOUR, RUN
   } picc_init_type;
   typedef enum logic {ACK_IDLE, ACK_SECOND} picc_ack_type;
endpackage

/* rtl/picc_arb_if.sv */
// carrier between control core and priority resolver
`timescale 1ns/1ps
interface picc_arb_if;
   logic [7:0] request_latch_register;
   logic [7:0] in_service_register;
   logic [7:0] mask;
   logic [7:0] casc_map;
   logic [2:0] bottom;
   logic       special_mask_select;
   logic       sfn_master;
   logic       win_valid;
   logic [2:0] win_lvl;
   logic       top_valid;
   logic [2:0] top_lvl;
   modport arb (input request_latch_register, in_service_register, mask, casc_map, bottom, special_mask_select, sfn_master,
                output win_valid, win_lvl, top_valid, top_lvl);
   modport ctl (output request_latch_register, in_service_register, mask, casc_map, bottom, special_mask_select, sfn_master,
                input win_valid, win_lvl, top_valid, top_lvl);
endinterface

/* rtl/picc_arbiter.sv */
// rotating priority resolver with in-service blocking
`timescale 1ns/1ps
module picc_arbiter (
   picc_arb_if.arb a
);
   logic [2:0] rank [picc_pkg::NLVL];
   logic [7:0] cand;
   logic       best_v;
   logic [2:0] best_r;
   logic [2:0] best_l;
   logic       top_v;
   logic [2:0] top_r;
   logic [2:0] top_l;
   logic       blocked;
   // ---------------------------------------------------------------
   // per-level rank, 0 is highest, level after bottom ranks first
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < picc_pkg::NLVL; i++) begin : g_lvl
         assign rank[i] = 3'(i) - a.bottom - 3'h1;
         assign cand[i] = a.request_latch_register[i] & ~a.mask[i];
      end
   endgenerate
   always_comb begin
      best_v = 1'b0;
      best_r = 3'h0;
      best_l = 3'h0;
      top_v  = 1'b0;
      top_r  = 3'h0;
      top_l  = 3'h0;
      for (int k = 0; k < picc_pkg::NLVL; k++) begin
         if (cand[k] && (!best_v || rank[k] < best_r)) begin
            best_v = 1'b1;
            best_r = rank[k];
            best_l = 3'(k);
         end
         if (a.in_service_register[k] && (!top_v || rank[k] < top_r)) begin
            top_v = 1'b1;
            top_r = rank[k];
            top_l = 3'(k);
         end
      end
   end
   // equal or lower rank waits unless the slave input may re-enter
   assign blocked = !a.special_mask_select && top_v &&
                    (best_r > top_r ||
                     (best_r == top_r &&
                      !(a.sfn_master && a.casc_map[best_l])));
   assign a.win_valid = best_v && !blocked;
   assign a.win_lvl   = best_l;
   assign a.top_valid = top_v;
   assign a.top_lvl   = top_l;
endmodule

/* rtl/picc_req_latch.sv */
// request latch, edge or level sensed, one mode shared by all inputs
`timescale 1ns/1ps
module picc_req_latch (
   input  logic       i_mclk,
   input  logic       i_rst_n,
   input  logic       i_ce,
   input  logic [7:0] i_req,
   input  logic       i_level_mode,
   input  logic [7:0] i_clr,
   input  logic       i_clr_all,
   output logic [7:0] o_irr
);
   logic [7:0] prev_q;
   genvar i;
   generate
      for (i = 0; i < picc_pkg::NLVL; i++) begin : g_bit
         always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
               prev_q[i] <= 1'b0;
               o_irr[i]  <= 1'b0;
            end else if (i_ce) begin
               // restart forces a fresh low-to-high after init
               prev_q[i] <= i_clr_all | i_req[i];
               if (i_clr_all)
                  o_irr[i] <= 1'b0;
               else if (i_level_mode)
                  o_irr[i] <= i_req[i];
               else if (i_req[i] && !prev_q[i])
                  o_irr[i] <= 1'b1;
               else if (i_clr[i])
                  o_irr[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

/* rtl/picc_top.sv */
// priority interrupt controller: command decode, service state, bus
//
// Functional notes
// - default fixed priority, line 0 highest, line 7 lowest.
// - nested mode holds off equal and lower levels, admits higher.
// - in-service bit stays until end command, or cleared by auto mode.
// - special nested master re-admits a slave input already in service.
// - rotate on end: serviced level becomes lowest, next one highest.
// - software names bottom level; set-priority command fixes it anytime.
// - specific end with rotate ends named level and makes it bottom.
// - special mask admits every unmasked level, masked ones stay blocked.
// - third command word with enable 1 and select 0 leaves special mask.
// - poll read acts as acknowledge and returns highest pending level.
// - service read needs selecting command, request read is the default; mask read needs none.
// - status read selection persists across repeated reads.
// - init is words one, two, four; word three only when cascaded.
// - first init word recognised by bits 0 and 4 set.
// - bit 1 of word one: 1 single, 0 cascaded needing word three.
// - bit 3 of word one: 0 rising edge, 1 high level triggers.
// - word two gives upper five type bits; level fills lower three.
// - master word three marks inputs with a slave attached.
// - slave answers second acknowledge only when cascade lines match id.
// - word four bit 0 is stored but never changes the type byte, bit 1 auto end.
// - word four: bit 3 buffered, bit 2 master if buffered (unbuffered is always master), bit 4 special nested.
`timescale 1ns/1ps
module picc_top (
   input  logic       i_mclk,
   input  logic       i_rst_n,
   input  logic       i_ce,
   input  logic       i_wr,
   input  logic       i_rd,
   input  logic       i_addr,
   input  logic [7:0] i_wdata,
   input  logic       i_ack,
   input  logic [7:0] i_request_inputs,
   input  logic [2:0] i_cas,
   output logic [7:0] o_bus_data,
   output logic       o_bus_data_oe,
   output logic       o_int,
   output logic [2:0] o_cas,
   output logic       o_cas_oe
);
   picc_arb_if arb_if ();
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   picc_pkg::picc_init_type init_q;
   picc_pkg::picc_init_type init_d;
   picc_pkg::picc_ack_type  ack_q;
   picc_pkg::picc_ack_type  ack_d;
   logic [7:0] req_s1_q, req_s2_q;
   logic [2:0] cas_s1_q, cas_s2_q;
   logic       single_q, level_q;
   logic [4:0] vec_base_q;
   logic [7:0] casc_q;
   logic       upm_q, aeoi_q, master_q, sfn_q;
   logic [7:0] mask_q, mask_d;
   logic [7:0] isr_q, isr_d;
   logic [2:0] bottom_q, bottom_d;
   logic       rot_aeoi_q, smm_q, read_isr_q, poll_q;
   logic [2:0] ack_lvl_q;
   logic       got_q, casc_drv_q;
   logic [7:0] request_latch_register;
   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire        running   = (init_q == picc_pkg::RUN);
   wire        wr_cmd    = i_wr && (i_addr == picc_pkg::PORT_CMD);
   wire        wr_data   = i_wr && (i_addr == picc_pkg::PORT_DATA);
   wire        is_init_word_one   = wr_cmd && i_wdata[picc_pkg::W1_ID0] &&
                           i_wdata[picc_pkg::W1_ID4];
   wire        is_ocw    = wr_cmd && running && !i_wdata[picc_pkg::W1_ID4];
   wire        is_ocw2   = is_ocw && !i_wdata[picc_pkg::OCW_SEL3];
   wire        is_third_operation_command_word   = is_ocw && i_wdata[picc_pkg::OCW_SEL3];
   wire        is_mask_command_word   = wr_data && running;
   wire [2:0]  code      = i_wdata[picc_pkg::OC2_HI:picc_pkg::OC2_LO];
   wire [2:0]  cmd_lvl   = i_wdata[2:0];
   wire        eoi_cmd   = is_ocw2 && code[picc_pkg::OC2_EOI_B];
   wire        eoi_spec  = code[picc_pkg::OC2_SPEC_B];
   wire        eoi_rot   = code[picc_pkg::OC2_ROT_B];
   wire [2:0]  eoi_lvl   = eoi_spec ? cmd_lvl : arb_if.top_lvl;
   wire        eoi_hit   = eoi_cmd && (eoi_spec || arb_if.top_valid);
   wire        set_pri   = is_ocw2 && (code == picc_pkg::OC2_SETPRI);
   wire        rot_on    = is_ocw2 && (code == picc_pkg::OC2_ROT_ON);
   wire        rot_off   = is_ocw2 && (code == picc_pkg::OC2_ROT_OFF);
   // ---------------------------------------------------------------
   // acknowledge and poll decode
   // ---------------------------------------------------------------
   wire        master_side = master_q || single_q;
   wire        ack1      = i_ack && running &&
                           (ack_q == picc_pkg::ACK_IDLE);
   wire        ack2      = i_ack && (ack_q == picc_pkg::ACK_SECOND);
   wire        id_hit    = (cas_s2_q == casc_q[2:0]);
   wire        casc_lvl  = master_q && !single_q &&
                           casc_q[arb_if.win_lvl];
   wire        rd_cmd    = i_rd && (i_addr == picc_pkg::PORT_CMD);
   wire        poll_rd   = rd_cmd && poll_q;
   wire        take_m    = ack1 && arb_if.win_valid && master_side;
   wire        take_s    = ack2 && got_q && !master_side && id_hit;
   wire        take_p    = poll_rd && arb_if.win_valid;
   wire        take      = take_m || take_s || take_p;
   wire [2:0]  take_lvl  = take_s ? ack_lvl_q : arb_if.win_lvl;
   wire        aeoi_end  = ack2 && aeoi_q && got_q &&
                           (master_side || id_hit);
   wire        drive_vec = ack2 &&
                           (master_side ? !casc_drv_q : id_hit);
   wire [7:0]  take_hot  = picc_pkg::ONE8 << take_lvl;
   wire [7:0]  set_v     = (take && !(take_s && aeoi_q)) ?
                           take_hot : picc_pkg::ZERO8;
   wire [7:0]  clr_eoi   = eoi_hit ? (picc_pkg::ONE8 << eoi_lvl) :
                           picc_pkg::ZERO8;
   wire [7:0]  clr_auto  = aeoi_end ? (picc_pkg::ONE8 << ack_lvl_q) :
                           picc_pkg::ZERO8;
   wire [7:0]  irr_clr   = take ? take_hot : picc_pkg::ZERO8;
   // ---------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------
   // a new acceptance wins over a clear of the same bit
   assign isr_d = is_init_word_one ? picc_pkg::ZERO8 :
                  ((isr_q & ~(clr_eoi | clr_auto)) | set_v);
   assign mask_d = is_init_word_one ? picc_pkg::MASK_RST :
                   (is_mask_command_word ? i_wdata : mask_q);
   assign bottom_d =
      is_init_word_one                           ? picc_pkg::BOTTOM_RST :
      (eoi_hit && eoi_rot)              ? eoi_lvl :
      set_pri                           ? cmd_lvl :
      (aeoi_end && rot_aeoi_q)          ? ack_lvl_q :
      bottom_q;
   wire [7:0] status_v = read_isr_q ? isr_q : request_latch_register;
   wire [7:0] poll_v   = {arb_if.win_valid, picc_pkg::POLL_PAD,
                          arb_if.win_lvl};
   wire [7:0] rd_mux   =
      (i_addr == picc_pkg::PORT_DATA) ? mask_q :
      poll_q                          ? poll_v :
      status_v;
   wire [7:0] vec_byte = {vec_base_q, ack_lvl_q};
   always_comb begin
      init_d = init_q;
      case (init_q)
         picc_pkg::INIT_VEC:
            if (wr_data)
               init_d = single_q ? picc_pkg::INIT_FOUR
                                 : picc_pkg::INIT_CASC;
         picc_pkg::INIT_CASC:
            if (wr_data)
               init_d = picc_pkg::INIT_FOUR;
         picc_pkg::INIT_FOUR:
            if (wr_data)
               init_d = picc_pkg::RUN;
         default:
            init_d = init_q;
      endcase
      if (is_init_word_one)
         init_d = picc_pkg::INIT_VEC;
   end
   always_comb begin
      ack_d = ack_q;
      case (ack_q)
         picc_pkg::ACK_IDLE:
            if (ack1)
               ack_d = picc_pkg::ACK_SECOND;
         default:
            if (ack2)
               ack_d = picc_pkg::ACK_IDLE;
      endcase
      if (is_init_word_one)
         ack_d = picc_pkg::ACK_IDLE;
   end
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         req_s1_q <= picc_pkg::ZERO8;
         req_s2_q <= picc_pkg::ZERO8;
         cas_s1_q <= 3'h0;
         cas_s2_q <= 3'h0;
      end else if (i_ce) begin
         req_s1_q <= i_request_inputs;
         req_s2_q <= req_s1_q;
         cas_s1_q <= i_cas;
         cas_s2_q <= cas_s1_q;
      end
   end
   // ---------------------------------------------------------------
   // initialization words
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         init_q     <= picc_pkg::INIT_WAIT;
         single_q   <= 1'b1;
         level_q    <= 1'b0;
         vec_base_q <= 5'h00;
         casc_q     <= picc_pkg::ZERO8;
         upm_q      <= 1'b0;
         aeoi_q     <= 1'b0;
         master_q   <= 1'b1;
         sfn_q      <= 1'b0;
      end else if (i_ce) begin
         init_q <= init_d;
         if (is_init_word_one) begin
            single_q <= i_wdata[picc_pkg::W1_SINGLE];
            level_q  <= i_wdata[picc_pkg::W1_LEVEL];
         end
         if (wr_data && init_q == picc_pkg::INIT_VEC)
            vec_base_q <= i_wdata[picc_pkg::VEC_HI:picc_pkg::VEC_LO];
         if (wr_data && init_q == picc_pkg::INIT_CASC)
            casc_q <= i_wdata;
         if (wr_data && init_q == picc_pkg::INIT_FOUR) begin
            upm_q    <= i_wdata[picc_pkg::W4_UPM];
            aeoi_q   <= i_wdata[picc_pkg::W4_AUTO];
            master_q <= !i_wdata[picc_pkg::W4_BUF] ||
                        i_wdata[picc_pkg::W4_MS];
            sfn_q    <= i_wdata[picc_pkg::W4_SFN];
         end
      end
   end
   // ---------------------------------------------------------------
   // service, mask and mode registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         isr_q      <= picc_pkg::ZERO8;
         mask_q     <= picc_pkg::MASK_RST;
         bottom_q   <= picc_pkg::BOTTOM_RST;
         rot_aeoi_q <= 1'b0;
         smm_q      <= 1'b0;
         read_isr_q <= 1'b0;
         poll_q     <= 1'b0;
      end else if (i_ce) begin
         isr_q    <= isr_d;
         mask_q   <= mask_d;
         bottom_q <= bottom_d;
         if (is_init_word_one || rot_off)
            rot_aeoi_q <= 1'b0;
         else if (rot_on)
            rot_aeoi_q <= 1'b1;
         if (is_init_word_one)
            smm_q <= 1'b0;
         else if (is_third_operation_command_word && i_wdata[picc_pkg::OC3_SPECIAL_MASK_WRITE_ENABLE])
            smm_q <= i_wdata[picc_pkg::OC3_SMM];
         if (is_init_word_one)
            read_isr_q <= 1'b0;
         else if (is_third_operation_command_word && i_wdata[picc_pkg::OC3_RR])
            read_isr_q <= i_wdata[picc_pkg::OC3_RIS];
         if (is_init_word_one || rd_cmd)
            poll_q <= 1'b0;
         else if (is_third_operation_command_word && i_wdata[picc_pkg::OC3_POLL])
            poll_q <= 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // acknowledge sequence and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ack_q         <= picc_pkg::ACK_IDLE;
         ack_lvl_q     <= picc_pkg::SPURIOUS_LVL;
         got_q         <= 1'b0;
         casc_drv_q    <= 1'b0;
         o_cas         <= 3'h0;
         o_cas_oe      <= 1'b0;
         o_bus_data    <= picc_pkg::ZERO8;
         o_bus_data_oe <= 1'b0;
         o_int         <= 1'b0;
      end else if (i_ce) begin
         ack_q <= ack_d;
         if (ack1) begin
            ack_lvl_q  <= arb_if.win_valid ? arb_if.win_lvl
                                           : picc_pkg::SPURIOUS_LVL;
            got_q      <= arb_if.win_valid;
            casc_drv_q <= casc_lvl;
            o_cas      <= arb_if.win_lvl;
            o_cas_oe   <= casc_lvl;
         end else if (ack2 || is_init_word_one) begin
            casc_drv_q <= 1'b0;
            o_cas_oe   <= 1'b0;
         end
         o_bus_data    <= i_rd ? rd_mux : vec_byte;
         o_bus_data_oe <= i_rd || drive_vec;
         o_int         <= arb_if.win_valid && running &&
                          (ack_d == picc_pkg::ACK_IDLE) && !take;
      end
   end
   // ---------------------------------------------------------------
   // submodules
   // ---------------------------------------------------------------
   assign arb_if.request_latch_register        = request_latch_register;
   assign arb_if.in_service_register        = isr_q;
   assign arb_if.mask       = mask_q;
   assign arb_if.casc_map   = casc_q;
   assign arb_if.bottom     = bottom_q;
   assign arb_if.special_mask_select        = smm_q;
   assign arb_if.sfn_master = sfn_q && master_q && !single_q;
   picc_arbiter u_arb (
      .a (arb_if.arb)
   );
   picc_req_latch u_latch (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_req        (req_s2_q),
      .i_level_mode (level_q),
      .i_clr        (irr_clr),
      .i_clr_all    (is_init_word_one),
      .o_irr        (request_latch_register)
   );
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_init_word_one_restart: assert property (
      i_ce && is_init_word_one |=> init_q == picc_pkg::INIT_VEC && isr_q == 8'h00)
      else $error("first init word did not restart");
   a_single_skips_three: assert property (
      i_ce && init_q == picc_pkg::INIT_VEC && wr_data && single_q
      |=> init_q == picc_pkg::INIT_FOUR)
      else $error("single mode did not skip cascade word");
   a_vector_byte: assert property (
      i_ce && drive_vec |=> o_bus_data_oe &&
      o_bus_data[2:0] == $past(ack_lvl_q) &&
      o_bus_data[7:3] == vec_base_q)
      else $error("type byte wrong");
   a_ack_sets_service: assert property (
      i_ce && take && !(take_s && aeoi_q) && !is_init_word_one
      |=> isr_q[$past(take_lvl)] && (!request_latch_register[$past(take_lvl)] || level_q))
      else $error("acknowledge did not move request to service");
   a_eoi_clears: assert property (
      i_ce && eoi_hit && !take |=> !isr_q[$past(eoi_lvl)])
      else $error("end command did not clear service bit");
   a_smm_exit: assert property (
      i_ce && is_third_operation_command_word && i_wdata[picc_pkg::OC3_SPECIAL_MASK_WRITE_ENABLE] &&
      !i_wdata[picc_pkg::OC3_SMM] |=> !smm_q)
      else $error("special mask not left");
   a_mask_read: assert property (
      i_ce && i_rd && i_addr == picc_pkg::PORT_DATA
      |=> o_bus_data_oe && o_bus_data == $past(mask_q))
      else $error("mask read wrong");
   a_rotate_bottom: assert property (
      i_ce && eoi_hit && eoi_rot |=> bottom_q == $past(eoi_lvl))
      else $error("rotate did not move bottom");
   a_slave_nomatch: assert property (
      i_ce && ack2 && !master_side && !id_hit |=> !o_bus_data_oe)
      else $error("slave drove type byte without id match");
   c_poll_read: cover property (i_ce && take_p);
   c_cascade_ack: cover property (i_ce && ack1 && casc_lvl ##[1:20] ack2);
   c_special_mask: cover property (smm_q && take_m);
endmodule

/* test/picc_cpu_model.sv */
// host acknowledge model: two pulses, takes the type byte
`timescale 1ns/1ps
module picc_cpu_model (
   input  wire logic       i_mclk,
   input  wire logic       i_oe,
   input  wire logic [7:0] i_data,
   output logic            o_ack
);
   initial o_ack = 1'b0;
   // two acknowledge pulses, two idle cycles between
   task automatic cycle(output logic [7:0] v, output logic ok);
      @(posedge i_mclk) o_ack <= 1'b1;
      @(posedge i_mclk) o_ack <= 1'b0;
      repeat (2) @(posedge i_mclk);
      o_ack <= 1'b1;
      @(posedge i_mclk) o_ack <= 1'b0;
      #1 v = i_data;
      ok = i_oe;
   endtask
endmodule

/* test/testbench.sv */
// self-checking bench of the priority interrupt controller
`timescale 1ns/1ps
module testbench;
   logic       i_mclk, i_rst_n, i_ce, i_wr, i_rd, i_addr, i_ack, ok;
   logic       o_int, o_cas_oe, o_bus_data_oe;
   logic [7:0] i_wdata, i_request_inputs, o_bus_data, v;
   logic [2:0] o_cas, i_cas;
   int         n_mismatch, checked;
   picc_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_ack(i_ack), .i_request_inputs(i_request_inputs), .i_cas(i_cas),
      .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
      .o_int(o_int), .o_cas(o_cas), .o_cas_oe(o_cas_oe));
   picc_cpu_model cpu_u (.i_mclk(i_mclk), .i_oe(o_bus_data_oe),
      .i_data(o_bus_data), .o_ack(i_ack));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(logic a, logic [7:0] d);
      @(posedge i_mclk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_mclk) i_wr <= 1'b0;
   endtask
   task automatic rd(logic a, logic [7:0] e, string nm);
      @(posedge i_mclk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_mclk) i_rd <= 1'b0;
      #1 chk({nm, "_oe"}, 8'h01, {7'h00, o_bus_data_oe});
      chk(nm, e, o_bus_data);
   endtask
   task automatic intchk(logic e);
      repeat (8) @(posedge i_mclk);
      #1 chk("int", {7'h00, e}, {7'h00, o_int});
   endtask
   task automatic req(logic [7:0] x);
      @(posedge i_mclk) i_request_inputs <= 8'h00;
      @(posedge i_mclk) i_request_inputs <= x;
   endtask
   task automatic ack(logic [7:0] e);
      cpu_u.cycle(v, ok);
      chk("type_oe", 8'h01, {7'h00, ok});
      chk("type", e, v);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_init;
      wr(1'b0, 8'h13);
      wr(1'b1, 8'h40);
      wr(1'b1, 8'h0d);
      rd(1'b1, 8'h00, "mask");
      wr(1'b1, 8'ha5);
      rd(1'b1, 8'ha5, "mask");
      // write while frozen must not land
      @(posedge i_mclk) i_ce <= 1'b0;
      wr(1'b1, 8'hff);
      @(posedge i_mclk) i_ce <= 1'b1;
      rd(1'b1, 8'ha5, "mask_frozen");
      wr(1'b1, 8'h00);
   endtask
   task automatic t_nest;
      req(8'h28);
      intchk(1'b1);
      ack(8'h43);
      intchk(1'b0);
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h08, "isr");
      rd(1'b0, 8'h08, "isr");
      wr(1'b0, 8'h20);
      intchk(1'b1);
      ack(8'h45);
      wr(1'b0, 8'h20);
   endtask
   task automatic t_poll_rot;
      req(8'h40);
      wr(1'b0, 8'h0c);
      rd(1'b0, 8'h86, "poll");
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h40, "isr");
      wr(1'b0, 8'h20);
      wr(1'b0, 8'hc5);
      req(8'h90);
      intchk(1'b1);
      ack(8'h47);
      wr(1'b0, 8'h20);
   endtask
   task automatic t_slave;
      i_cas <= 3'h5;
      wr(1'b0, 8'h19);
      wr(1'b1, 8'h10);
      wr(1'b1, 8'h05);
      wr(1'b1, 8'h09);
      req(8'h04);
      intchk(1'b1);
      ack(8'h12);
      req(8'h00);
      wr(1'b0, 8'h20);
      wr(1'b0, 8'h0b);
      rd(1'b0, 8'h00, "slave_isr");
      i_cas <= 3'h3;
      req(8'h04);
      intchk(1'b1);
      cpu_u.cycle(v, ok);
      chk("slave_oe", 8'h00, {7'h00, ok});
      rd(1'b0, 8'h00, "isr");
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   initial begin
      {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_request_inputs, i_cas} = '0;
      i_ce = 1'b1;
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_init;
      t_nest;
      t_poll_rot;
      t_slave;
      end_of_test;
   end
   initial begin
      #200000;
      n_mismatch++;
      end_of_test;
   end
endmodule
